// file: bin_sweep_pkg.sv
// constants for the bin tally and list sweep block
// assumes a single 200 MHz clock and a synchronous active-high reset
package bin_sweep_pkg;

  // ==================================================
  // register bus
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_CMD     = 8'h04;
  localparam logic [7:0]  OFS_LEN     = 8'h08;
  localparam logic [7:0]  OFS_STATUS  = 8'h0c;
  localparam logic [7:0]  OFS_IRQ_ST  = 8'h10;
  localparam logic [7:0]  OFS_IRQ_MSK = 8'h14;
  localparam logic [7:0]  OFS_OVF     = 8'h18;
  localparam logic [7:0]  OFS_RESULT  = 8'h1c;
  localparam logic [7:0]  OFS_TALLY   = 8'h40;
  localparam logic [7:0]  OFS_LIST    = 8'h80;

  // ==================================================
  // field positions
  localparam int CTRL_CNT_EN = 0;
  localparam int CTRL_WHOLE  = 3;
  localparam int CTRL_SRC_LO = 4;
  localparam int CMD_CLEAR   = 0;
  localparam int CMD_ENTER   = 1;
  localparam int CMD_LEAVE   = 2;
  localparam int CMD_REMOTE  = 3;
  localparam int IRQ_OVF     = 0;
  localparam int IRQ_POINT   = 1;
  localparam int IRQ_SWEEP   = 2;
  localparam int IRQ_W       = 3;
  localparam int LIST_KIND   = 24;
  localparam int STAT_BUSY   = 8;
  localparam int STAT_ACTIVE = 9;
  localparam int RES_DONE_LO = 16;
  localparam int TALLY_FLAG  = 31;

  // ==================================================
  // tallies
  localparam int              NUM_BINS   = 9;
  localparam int              NUM_TALLY  = 11;
  localparam int              TALLY_SEC  = 9;
  localparam int              TALLY_OUT  = 10;
  localparam int              TALLY_W    = 20;
  localparam logic [19:0]     TALLY_MAX  = 20'hf423f;
  localparam logic [3:0]      CODE_OUT   = 4'ha;

  // ==================================================
  // sweep list
  localparam int          LIST_MAX    = 10;
  localparam int          IDX_W       = 4;
  localparam int          VAL_W       = 24;
  localparam logic [3:0]  LEN_MAX     = 4'ha;
  localparam logic [3:0]  LEN_RST     = 4'ha;
  localparam logic        CNT_EN_RST  = 1'b1;
  localparam logic        WHOLE_RST   = 1'b1;

  typedef enum logic [1:0] {
    SRC_INTERNAL         = 2'b00,
    SRC_MANUAL_KEY       = 2'b01,
    SRC_HANDLER_PIN      = 2'b10,
    SRC_REMOTE           = 2'b11
  } trig_src_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_MEAS = 1'b1
  } sweep_state_t;

endpackage

// file: sat_tally.sv
// one saturating outcome tally with overflow flag
// assumes inc and clr are single-cycle qualified events
`timescale 1ns/1ps
`default_nettype none
module sat_tally
(
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          srst,
  // control
  input  wire logic                          clr,
  input  wire logic                          inc,
  // state
  output logic [bin_sweep_pkg::TALLY_W-1:0]  count,
  output logic                               ovf
);
  import bin_sweep_pkg::*;

  logic [TALLY_W-1:0] cnt_ff;

  // ==================================================
  // counter
  always_ff @(posedge clk_sys) begin
    if (srst || clr) begin
      cnt_ff <= '0;
    end else if (inc && (cnt_ff != TALLY_MAX)) begin
      cnt_ff <= cnt_ff + 20'h00001;
    end
  end

  assign count = cnt_ff;
  assign ovf   = (cnt_ff == TALLY_MAX);

endmodule
`default_nettype wire

// file: bin_tally_and_list_sweep.sv
// comparator outcome tallies and list sweep sequencer
// assumes measurement engine answers each measStart with one measDone pulse
// all inputs are synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - each tally stops counting once it holds 999999.
// - a tally at its maximum raises its own overflow flag.
// - clear-all zeroes all eleven tallies in the same cycle.
// - nine bin tallies plus secondary-fail and out-of-bin tallies.
// - secondary-fail tally counts only parts with secondary outside limits.
// - with counting disabled, outcomes change no tally.
// - the sweep list holds at most ten frequency or level points.
// - each swept point records its own pass or fail result.
// - index of the point being measured is shown during a sweep.
// - entering list sweep selects manual source and acts on one trigger unprompted.
// - internal source sweeps the list continuously without any trigger.
// - manual source advances once per trigger key event.
// - handler source advances once per rising edge of the handler pin.
// - remote source measures one point per remote trigger command.
// - whole-list mode measures the points from the current index to the last on one trigger, except from the remote source.
// - single-point mode measures exactly one point per trigger, then halts.
// - whole-list manual runs to the last step then waits for a key.
// - single-point manual runs the first step alone, then waits per step.
module bin_tally_and_list_sweep
(
  // clock and reset
  input  wire logic                              clk_sys,
  input  wire logic                              srst,
  // register port
  input  wire logic [bin_sweep_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [bin_sweep_pkg::DATA_W-1:0]  regWdata,
  input  wire logic                              regWr,
  input  wire logic                              regRd,
  output logic [bin_sweep_pkg::DATA_W-1:0]       regRdata,
  // comparator outcomes
  input  wire logic                              outcomeValid,
  input  wire logic [3:0]                        outcomeBin,
  input  wire logic                              outcomeSecFail,
  // trigger sources
  input  wire logic                              trigKey,
  input  wire logic                              handlerTrig,
  // measurement engine
  output logic                                   measStart,
  output logic [bin_sweep_pkg::VAL_W-1:0]        measValue,
  output logic                                   measIsLevel,
  input  wire logic                              measDone,
  input  wire logic                              measPass,
  // status
  output logic [bin_sweep_pkg::IDX_W-1:0]        activeIdx,
  output logic                                   sweepBusy,
  output logic                                   irq
);
  import bin_sweep_pkg::*;

  // ==================================================
  // declarations
  logic                   cntEn_ff;
  logic                   whole_list_mode_ff;
  trig_src_t              trigSrc_ff;
  logic [IDX_W-1:0]       listLen_ff;
  logic [VAL_W:0]         listMem [LIST_MAX];
  logic [LIST_MAX-1:0]    passRes_ff;
  logic [LIST_MAX-1:0]    doneRes_ff;
  logic [IRQ_W-1:0]       irqSt_ff;
  logic [IRQ_W-1:0]       irqMsk_ff;
  logic [IRQ_W-1:0]       irqEvt;
  logic [DATA_W-1:0]      rdata_ff;
  logic [DATA_W-1:0]      nxt_rdata;
  logic                   listActive_ff;
  logic                   autoPend_ff;
  logic                   handlerPrev_ff;
  logic                   runAll_ff;
  sweep_state_t           state_ff;
  logic [IDX_W-1:0]       pointIdx_ff;
  logic                   measStart_ff;
  logic [VAL_W-1:0]       measValue_ff;
  logic                   measIsLevel_ff;
  logic                   wrCtrl;
  logic                   wrCmd;
  logic                   cmdClear;
  logic                   cmdEnter;
  logic                   cmdLeave;
  logic                   cmdRemote;
  logic                   srcEvt;
  logic                   trigEvt;
  logic                   startRun;
  logic                   lastPoint;
  logic                   continueRun;
  logic [IDX_W-1:0]       nxtIdx;
  logic                   ovfRise;
  logic [NUM_TALLY-1:0]   tallyInc;
  logic [NUM_TALLY-1:0]   tallyOvf;
  logic [NUM_TALLY-1:0]   tallyOvfPrev_ff;
  logic [TALLY_W-1:0]     tallyCnt [NUM_TALLY];

  // ==================================================
  // register write decode
  assign wrCtrl    = regWr && (regAddr == OFS_CTRL);
  assign wrCmd     = regWr && (regAddr == OFS_CMD);
  assign cmdClear  = wrCmd && regWdata[CMD_CLEAR];
  assign cmdEnter  = wrCmd && regWdata[CMD_ENTER];
  assign cmdLeave  = wrCmd && regWdata[CMD_LEAVE];
  assign cmdRemote = wrCmd && regWdata[CMD_REMOTE];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cntEn_ff           <= CNT_EN_RST;
      whole_list_mode_ff <= WHOLE_RST;
      trigSrc_ff         <= SRC_MANUAL_KEY;
    end else if (cmdEnter) begin
      trigSrc_ff <= SRC_MANUAL_KEY;
    end else if (wrCtrl) begin
      cntEn_ff           <= regWdata[CTRL_CNT_EN];
      whole_list_mode_ff <= regWdata[CTRL_WHOLE];
      trigSrc_ff         <= trig_src_t'(regWdata[CTRL_SRC_LO +: 2]);
    end
  end

  // length outside 1..10 is clamped so the index never runs past the list
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      listLen_ff <= LEN_RST;
    end else if (regWr && (regAddr == OFS_LEN)) begin
      if (regWdata[IDX_W-1:0] == '0) begin
        listLen_ff <= 4'h1;
      end else if (regWdata[IDX_W-1:0] > LEN_MAX) begin
        listLen_ff <= LEN_MAX;
      end else begin
        listLen_ff <= regWdata[IDX_W-1:0];
      end
    end
  end

  // point table: value in low bits, kind bit set for a level point
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < LIST_MAX; i++) begin
      if (srst) begin
        listMem[i] <= '0;
      end else if (regWr && (regAddr == OFS_LIST + 8'(4 * i))) begin
        listMem[i] <= regWdata[VAL_W:0];
      end
    end
  end

  // ==================================================
  // tallies
  generate
    for (genvar t = 0; t < NUM_TALLY; t++) begin : g_tally
      if (t < NUM_BINS) begin : g_bin
        assign tallyInc[t] = cntEn_ff && outcomeValid
                             && (outcomeBin == 4'(t + 1));
      end else if (t == TALLY_SEC) begin : g_sec
        assign tallyInc[t] = cntEn_ff && outcomeValid && outcomeSecFail;
      end else begin : g_out
        assign tallyInc[t] = cntEn_ff && outcomeValid
                             && (outcomeBin == CODE_OUT);
      end
      sat_tally u_tally (
        .clk_sys (clk_sys),
        .srst    (srst),
        .clr     (cmdClear),
        .inc     (tallyInc[t]),
        .count   (tallyCnt[t]),
        .ovf     (tallyOvf[t])
      );
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tallyOvfPrev_ff <= '0;
    end else begin
      tallyOvfPrev_ff <= tallyOvf;
    end
  end

  assign ovfRise = |(tallyOvf & ~tallyOvfPrev_ff);

  // ==================================================
  // trigger selection
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      handlerPrev_ff <= 1'b0;
    end else begin
      handlerPrev_ff <= handlerTrig;
    end
  end

  always_comb begin
    unique case (trigSrc_ff)
      SRC_INTERNAL:    srcEvt = 1'b1;
      SRC_MANUAL_KEY:  srcEvt = trigKey;
      SRC_HANDLER_PIN: srcEvt = handlerTrig && !handlerPrev_ff;
      SRC_REMOTE:      srcEvt = cmdRemote;
    endcase
  end

  // triggers arriving mid-run are dropped, not queued
  assign trigEvt     = listActive_ff && (autoPend_ff || srcEvt);
  assign startRun    = (state_ff == ST_IDLE) && trigEvt && !cmdLeave && !cmdEnter;
  assign lastPoint   = (pointIdx_ff >= listLen_ff - 4'h1);
  assign continueRun = runAll_ff && !lastPoint && listActive_ff && !cmdEnter;
  assign nxtIdx      = lastPoint ? '0 : pointIdx_ff + 4'h1;

  // ==================================================
  // sweep sequencer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      listActive_ff <= 1'b0;
      autoPend_ff   <= 1'b0;
    end else if (cmdEnter) begin
      listActive_ff <= 1'b1;
      autoPend_ff   <= 1'b1;
    end else if (cmdLeave) begin
      listActive_ff <= 1'b0;
      autoPend_ff   <= 1'b0;
    end else if (startRun) begin
      autoPend_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || cmdEnter) begin
      state_ff    <= ST_IDLE;
      pointIdx_ff <= '0;
      runAll_ff   <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (startRun) begin
            state_ff  <= ST_MEAS;
            // remote commands always take a single point
            runAll_ff <= whole_list_mode_ff
                         && (trigSrc_ff != SRC_REMOTE);
          end
        end
        ST_MEAS: begin
          if (measDone) begin
            pointIdx_ff <= nxtIdx;
            if (!continueRun) begin
              state_ff <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // start pulse and point data for the engine
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      measStart_ff   <= 1'b0;
      measValue_ff   <= '0;
      measIsLevel_ff <= 1'b0;
    end else if (startRun) begin
      measStart_ff   <= 1'b1;
      measValue_ff   <= listMem[pointIdx_ff][VAL_W-1:0];
      measIsLevel_ff <= listMem[pointIdx_ff][LIST_KIND];
    end else if ((state_ff == ST_MEAS) && measDone && continueRun) begin
      measStart_ff   <= 1'b1;
      measValue_ff   <= listMem[nxtIdx][VAL_W-1:0];
      measIsLevel_ff <= listMem[nxtIdx][LIST_KIND];
    end else begin
      measStart_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || cmdEnter) begin
      passRes_ff <= '0;
      doneRes_ff <= '0;
    end else if ((state_ff == ST_MEAS) && measDone) begin
      passRes_ff[pointIdx_ff] <= measPass;
      doneRes_ff[pointIdx_ff] <= 1'b1;
    end
  end

  // ==================================================
  // interrupts
  assign irqEvt[IRQ_OVF]   = ovfRise;
  assign irqEvt[IRQ_POINT] = (state_ff == ST_MEAS) && measDone;
  assign irqEvt[IRQ_SWEEP] = (state_ff == ST_MEAS) && measDone && lastPoint;

  // a new event wins over a simultaneous write-one clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irqSt_ff <= '0;
    end else if (regWr && (regAddr == OFS_IRQ_ST)) begin
      irqSt_ff <= (irqSt_ff & ~regWdata[IRQ_W-1:0]) | irqEvt;
    end else begin
      irqSt_ff <= irqSt_ff | irqEvt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irqMsk_ff <= '0;
    end else if (regWr && (regAddr == OFS_IRQ_MSK)) begin
      irqMsk_ff <= regWdata[IRQ_W-1:0];
    end
  end

  // ==================================================
  // read port
  always_comb begin
    nxt_rdata = '0;
    if (regAddr == OFS_CTRL) begin
      nxt_rdata[CTRL_CNT_EN]        = cntEn_ff;
      nxt_rdata[CTRL_WHOLE]         = whole_list_mode_ff;
      nxt_rdata[CTRL_SRC_LO +: 2]   = trigSrc_ff;
    end else if (regAddr == OFS_LEN) begin
      nxt_rdata[IDX_W-1:0] = listLen_ff;
    end else if (regAddr == OFS_STATUS) begin
      nxt_rdata[IDX_W-1:0] = pointIdx_ff;
      nxt_rdata[STAT_BUSY]   = state_ff == ST_MEAS;
      nxt_rdata[STAT_ACTIVE] = listActive_ff;
    end else if (regAddr == OFS_IRQ_ST) begin
      nxt_rdata[IRQ_W-1:0] = irqSt_ff;
    end else if (regAddr == OFS_IRQ_MSK) begin
      nxt_rdata[IRQ_W-1:0] = irqMsk_ff;
    end else if (regAddr == OFS_OVF) begin
      nxt_rdata[NUM_TALLY-1:0] = tallyOvf;
    end else if (regAddr == OFS_RESULT) begin
      nxt_rdata[LIST_MAX-1:0]       = passRes_ff;
      nxt_rdata[RES_DONE_LO +: LIST_MAX] = doneRes_ff;
    end else begin
      for (int i = 0; i < NUM_TALLY; i++) begin
        if (regAddr == OFS_TALLY + 8'(4 * i)) begin
          nxt_rdata[TALLY_W-1:0] = tallyCnt[i];
          nxt_rdata[TALLY_FLAG]  = tallyOvf[i];
        end
      end
      for (int i = 0; i < LIST_MAX; i++) begin
        if (regAddr == OFS_LIST + 8'(4 * i)) begin
          nxt_rdata[VAL_W:0] = listMem[i];
        end
      end
    end
  end

  // read data valid only the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys) begin
    if (srst || !regRd) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ==================================================
  // outputs
  assign regRdata    = rdata_ff;
  assign measStart   = measStart_ff;
  assign measValue   = measValue_ff;
  assign measIsLevel = measIsLevel_ff;
  assign activeIdx   = pointIdx_ff;
  assign sweepBusy   = (state_ff == ST_MEAS);
  assign irq         = |(irqSt_ff & irqMsk_ff);

endmodule
`default_nettype wire

// file: bin_sweep_checker.sv
// port assertions for the sweep sequencer of bin_tally_and_list_sweep
// assumes one clock and a reset held at least three cycles
`timescale 1ns/1ps
`default_nettype none
module bin_sweep_checker
(
  // clock and reset
  input wire logic                            clk_sys,
  input wire logic                            srst,
  // sweep ports
  input wire logic                            measStart,
  input wire logic [bin_sweep_pkg::VAL_W-1:0] measValue,
  input wire logic                            measDone,
  input wire logic [bin_sweep_pkg::IDX_W-1:0] activeIdx,
  input wire logic                            sweepBusy
);
  import bin_sweep_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ==================================================
  // sequencing
  AST_IDX_RANGE:
    assert property (activeIdx <= 4'h9) else $error("active index beyond last point");
  AST_START_BUSY:
    assert property (measStart |-> sweepBusy) else $error("start without busy");
  AST_BUSY_HOLD:
    assert property (sweepBusy && !measDone |=> sweepBusy) else $error("busy dropped early");
  AST_IDX_HOLD:
    assert property (sweepBusy && !measDone |=> $stable(activeIdx))
      else $error("index moved mid point");
  AST_IDX_STEP:
    assert property (sweepBusy && measDone |=>
      (activeIdx == $past(activeIdx) + 4'h1) || (activeIdx == 4'h0))
      else $error("index did not step or wrap");
  AST_NO_EXTRA_START:
    assert property (sweepBusy && !measDone |=> !measStart) else $error("start while busy");
  AST_START_PULSE:
    assert property (measStart |=> !measStart [*2]) else $error("start longer than one cycle");
  // value changes only with a start; relies on reset lasting over two edges
  AST_VALUE_AT_START:
    assert property ($changed(measValue) |-> measStart) else $error("value changed alone");
  // ==================================================
  // coverage
  COV_DONE: cover property (sweepBusy && measDone);
  COV_LAST: cover property (measStart && activeIdx == 4'h2);
  COV_WRAP: cover property (sweepBusy && measDone ##1 activeIdx == 4'h0);
endmodule

bind bin_tally_and_list_sweep bin_sweep_checker i_chk (
  .clk_sys   (clk_sys),
  .srst      (srst),
  .measStart (measStart),
  .measValue (measValue),
  .measDone  (measDone),
  .activeIdx (activeIdx),
  .sweepBusy (sweepBusy)
);
`default_nettype wire

// file: meas_engine_model.sv
// behavioural measurement engine answering each start with one done pulse
// assumes starts come only when the previous point has finished
`timescale 1ns/1ps
`default_nettype none
module meas_engine_model
(
  // clock and reset
  input  wire logic                            clk_sys,
  input  wire logic                            srst,
  // engine port
  input  wire logic                            measStart,
  input  wire logic [bin_sweep_pkg::VAL_W-1:0] measValue,
  input  wire logic                            slow,
  output logic                                 measDone,
  output logic                                 measPass
);
  import bin_sweep_pkg::*;
  logic [3:0] waitCnt;
  logic       busy;
  logic       passBit;
  logic       lastWait;
  assign lastWait = busy && !measStart && (waitCnt == 4'h0);
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      busy     <= 1'b0;
      waitCnt  <= 4'h0;
      passBit  <= 1'b0;
      measDone <= 1'b0;
      measPass <= 1'b0;
    end else begin
      measDone <= lastWait;
      // toggles outside done so a stale level is never taken as a verdict
      measPass <= lastWait ? passBit : ~measPass;
      if (measStart) begin
        busy    <= 1'b1;
        waitCnt <= slow ? 4'hc : 4'h1;
        passBit <= measValue[0];
      end else if (lastWait) begin
        busy <= 1'b0;
      end else if (busy) begin
        waitCnt <= waitCnt - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: bin_tally_and_list_sweep_tb.sv
// self-checking bench: register port tasks, outcome and trigger drivers
// assumes the design package and the engine model are compiled first
`timescale 1ns/1ps
`default_nettype none
module bin_tally_and_list_sweep_tb;
  import bin_sweep_pkg::*;
  logic              clk_sys = 1'b0;
  logic              srst = 1'b1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWdata = '0;
  logic              regWr = 1'b0;
  logic              regRd = 1'b0;
  logic [DATA_W-1:0] regRdata;
  logic              outcomeValid = 1'b0;
  logic [3:0]        outcomeBin = 4'h0;
  logic              outcomeSecFail = 1'b0;
  logic              trigKey = 1'b0;
  logic              handlerTrig = 1'b0;
  logic              measStart, measIsLevel, measDone, measPass, sweepBusy, irq, slow = 1'b0;
  logic [VAL_W-1:0]  measValue;
  logic [IDX_W-1:0]  activeIdx;
  logic [DATA_W-1:0] rd;
  logic [28:0]       startLog[$];
  int                n_errors = 0;
  int                checked = 0;
  int                expIdx = 0;
  always #2.5 clk_sys = ~clk_sys;
  bin_tally_and_list_sweep i_dut (.clk_sys(clk_sys), .srst(srst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .outcomeValid(outcomeValid), .outcomeBin(outcomeBin), .outcomeSecFail(outcomeSecFail),
    .trigKey(trigKey), .handlerTrig(handlerTrig), .measStart(measStart),
    .measValue(measValue), .measIsLevel(measIsLevel), .measDone(measDone),
    .measPass(measPass), .activeIdx(activeIdx), .sweepBusy(sweepBusy), .irq(irq));
  meas_engine_model i_eng (.clk_sys(clk_sys), .srst(srst), .measStart(measStart),
    .measValue(measValue), .slow(slow), .measDone(measDone), .measPass(measPass));
  always @(posedge clk_sys) if (measStart) startLog.push_back({activeIdx, measIsLevel, measValue});
  // ==================================================
  // tasks
  task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic expectReg(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys);
    check32(what, exp, regRdata);
    @(negedge clk_sys);
    check32("read idle", 32'h0, regRdata);
  endtask
  task automatic sendOutcome(input logic [3:0] b, input logic sec);
    @(posedge clk_sys);
    outcomeValid <= 1'b1;
    outcomeBin <= b;
    outcomeSecFail <= sec;
    @(posedge clk_sys);
    outcomeValid <= 1'b0;
  endtask
  task automatic pressKey();
    @(posedge clk_sys);
    trigKey <= 1'b1;
    @(posedge clk_sys);
    trigKey <= 1'b0;
  endtask
  // held several cycles: only the rising edge may count
  task automatic handlerPulse();
    @(posedge clk_sys);
    handlerTrig <= 1'b1;
    repeat (30) @(posedge clk_sys);
    handlerTrig <= 1'b0;
  endtask
  task automatic checkIrq(input logic exp);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check32("irq", {31'h0, exp}, {31'h0, irq});
  endtask
  // point i holds value 0x100+i, level kind on odd points
  task automatic runExpect(input int n, input bit exact);
    int i;
    i = 0;
    while (startLog.size() < n && i < 800) begin
      @(posedge clk_sys);
      i++;
    end
    // a single run must stop at n, continuous sweeping must keep starting
    repeat (40) @(posedge clk_sys);
    check32("one run only", 32'(exact), 32'(startLog.size() == n));
    check32("too few starts", 32'h0, 32'(startLog.size() < n));
    for (i = 0; i < n && i < startLog.size(); i++) begin
      check32("start point", {3'h0, 4'(expIdx), expIdx[0], 24'h000100 + 24'(expIdx)},
              {3'h0, startLog[i]});
      expIdx = (expIdx + 1) % 3;
    end
    startLog.delete();
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==================================================
  // watchdog: all tests need well under two thousand cycles
  initial begin
    repeat (30000) @(posedge clk_sys);
    n_errors++;
    print_verdict();
  end
  // ==================================================
  // tests
  initial begin
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    expectReg("ctrl reset", OFS_CTRL, 32'h00000019);
    regWrite(8'h20, 32'hffffffff);
    expectReg("unmapped", 8'h20, 32'h0);
    for (int k = 1; k <= 10; k++) sendOutcome(4'(k), k == 3);
    sendOutcome(4'h0, 1'b0);
    sendOutcome(4'hb, 1'b0);
    for (int t = 0; t < NUM_TALLY; t++) expectReg("tally", OFS_TALLY + 8'(4 * t), 32'h1);
    regWrite(OFS_CTRL, 32'h18);
    sendOutcome(4'h1, 1'b1);
    expectReg("tally off", OFS_TALLY, 32'h1);
    expectReg("aux off", OFS_TALLY + 8'(4 * TALLY_SEC), 32'h1);
    regWrite(OFS_CTRL, 32'h19);
    regWrite(OFS_CMD, 32'h1);
    for (int t = 0; t < NUM_TALLY; t++) expectReg("cleared", OFS_TALLY + 8'(4 * t), 32'h0);
    expectReg("overflow", OFS_OVF, 32'h0);
    $display("tally test done");
    regWrite(OFS_LEN, 32'hf);
    expectReg("len clamp", OFS_LEN, 32'ha);
    regWrite(OFS_LEN, 32'h3);
    for (int i = 0; i < 3; i++) regWrite(OFS_LIST + 8'(4 * i), {7'h0, 1'(i), 24'h000100 + 24'(i)});
    regWrite(OFS_CTRL, 32'h09);
    regWrite(OFS_CMD, 32'h2);
    runExpect(3, 1'b1);
    expectReg("ctrl manual", OFS_CTRL, 32'h19);
    expectReg("result", OFS_RESULT, 32'h00070002);
    expectReg("status", OFS_STATUS, 32'h00000200);
    expectReg("irq status", OFS_IRQ_ST, 32'h6);
    checkIrq(1'b0);
    regWrite(OFS_IRQ_MSK, 32'h4);
    checkIrq(1'b1);
    regWrite(OFS_IRQ_ST, 32'h6);
    checkIrq(1'b0);
    slow <= 1'b1;
    pressKey();
    runExpect(3, 1'b1);
    $display("whole list test done");
    regWrite(OFS_CTRL, 32'h11);
    regWrite(OFS_CMD, 32'h2);
    runExpect(1, 1'b1);
    repeat (3) begin
      pressKey();
      runExpect(1, 1'b1);
    end
    regWrite(OFS_CTRL, 32'h21);
    repeat (2) begin
      handlerPulse();
      runExpect(1, 1'b1);
    end
    regWrite(OFS_CTRL, 32'h39);
    regWrite(OFS_CMD, 32'h8);
    runExpect(1, 1'b1);
    $display("single point test done");
    slow <= 1'b0;
    regWrite(OFS_CTRL, 32'h09);
    runExpect(9, 1'b0);
    regWrite(OFS_CTRL, 32'h19);
    repeat (200) @(posedge clk_sys);
    startLog.delete();
    regWrite(OFS_CMD, 32'h4);
    pressKey();
    repeat (40) @(posedge clk_sys);
    check32("start after leave", 32'h0, 32'(startLog.size()));
    $display("internal and leave test done");
    print_verdict();
  end
endmodule
`default_nettype wire
